// [logic/alu_branch_pkg.sv]
`default_nettype none
package alu_branch_pkg;
  localparam int DATA_W = 8;
  localparam int PC_W = 11;
  localparam int OFFSET_W = 7;
  localparam int OP_W = 6;
  // status bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [10:0] PC_RESET = 11'h000;
  localparam logic [10:0] PC_STEP_ONE = 11'h001;
  localparam logic [10:0] PC_STEP_TWO = 11'h002;
  localparam logic [10:0] PC_STEP_THREE = 11'h003;
  // operation codes presented by decode
  typedef enum logic [5:0] {
    op_nop = 6'h00,
    op_add = 6'h01,
    op_add_carry = 6'h02,
    op_minus = 6'h03,
    op_minus_with_borrow = 6'h04,
    op_minus_immediate = 6'h05,
    op_minus_borrow_immediate = 6'h06,
    op_and = 6'h07,
    op_mask_immediate = 6'h08,
    op_or = 6'h09,
    op_disjunction_immediate = 6'h0A,
    op_exclusive_or_reg = 6'h0B,
    op_set_bits_masked = 6'h0C,
    op_clear_bits_masked = 6'h0D,
    op_zero_minus_test = 6'h0E,
    op_zero_register = 6'h0F,
    op_all_ones_load = 6'h10,
    op_compare_op = 6'h11,
    op_compare_with_borrow = 6'h12,
    op_compare_immediate = 6'h13,
    op_equal_skip = 6'h14,
    op_skip_reg_bit_clear = 6'h15,
    op_skip_reg_bit_high = 6'h16,
    op_skip_port_bit_clear = 6'h17,
    op_skip_port_bit_high = 6'h18,
    op_flag_set_jump = 6'h19,
    op_flag_clear_jump = 6'h1A,
    op_signed_ge_jump = 6'h1B,
    op_signed_less_jump = 6'h1C,
    op_carry_high_jump = 6'h1D,
    op_carry_low_jump = 6'h1E,
    op_unsigned_ge_jump = 6'h1F,
    op_unsigned_less_jump = 6'h20,
    op_half_carry_high_jump = 6'h21,
    op_half_carry_low_jump = 6'h22,
    op_overflow_high_jump = 6'h23,
    op_overflow_low_jump = 6'h24,
    op_irq_enabled_jump = 6'h25,
    op_irq_disabled_jump = 6'h26,
    op_transfer_bit_high_jump = 6'h27,
    op_transfer_bit_low_jump = 6'h28
  } op_t;
  typedef enum logic [1:0] {
    st_ready = 2'b00,
    st_stall = 2'b01,
    st_stall_two = 2'b11
  } state_t;
endpackage
`default_nettype wire

// [logic/alu_branch_execute.sv]
// Contract
// - add and add-with-carry write sum, set ZCNVH
// - subtract and borrow-subtract write difference, set ZCNVH
// - immediate subtract forms write difference, set ZCNVH
// - AND forms write result, set ZNVS only
// - OR forms and XOR write result, ZNV
// - masked set ORs mask, clear ANDs complement
// - test, clear set ZNV; ones-load no flags
// - compares discard result, set ZNVCH
// - equal registers skip next instruction
// - register bit test skips on clear/set
// - port bit test skips on clear/set
// - selected status bit branches PC+k+1
// - signed branches test N xor V
// - carry branches; unsigned forms alias them
// - half-carry branches on H set/clear
// - overflow branches on V set/clear
// - interrupt-enable branches on I set/clear
// - transfer-bit branches on T set/clear
`default_nettype none
module alu_branch_execute
(
  input wire logic clock,
  input wire logic reset,
  input wire logic issue,
  input wire logic [5:0] opcode,
  input wire logic [7:0] dest_value,
  input wire logic [7:0] src_value,
  input wire logic [7:0] immediate,
  input wire logic [2:0] bit_select,
  input wire logic [7:0] port_value,
  input wire logic [6:0] offset,
  input wire logic next_is_two_word,
  input wire logic status_write,
  input wire logic [7:0] status_write_data,
  output logic ready,
  output logic [7:0] result,
  output logic result_write,
  output logic [7:0] status_flags_reg,
  output logic [10:0] pc,
  output logic pc_load
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    alu_branch_pkg::state_t state;
    logic [7:0] result;
    logic result_write;
    logic [7:0] status;
    logic [10:0] pc;
    logic pc_load;
  } regs_t;

  regs_t cur;
  regs_t next_cur;

  // ************************************************************
  // datapath
  // ************************************************************
  logic [7:0] opnd_b;
  logic carry_in;
  logic is_add;
  logic is_sub;
  logic is_logic;
  logic is_cmp;
  logic [8:0] sum;
  logic [7:0] logic_out;
  logic [7:0] arith_out;
  logic h_flag;
  logic v_flag;
  logic cond;
  logic is_branch;
  logic is_skip;
  logic [10:0] rel;

  always_comb
  begin
    is_add = 1'b0;
    is_sub = 1'b0;
    is_logic = 1'b0;
    is_cmp = 1'b0;
    carry_in = 1'b0;
    opnd_b = src_value;
    logic_out = dest_value;
    unique case (alu_branch_pkg::op_t'(opcode))
      alu_branch_pkg::op_add:
        is_add = 1'b1;
      alu_branch_pkg::op_add_carry:
      begin
        is_add = 1'b1;
        carry_in = cur.status[alu_branch_pkg::FLAG_C];
      end
      alu_branch_pkg::op_minus:
        is_sub = 1'b1;
      alu_branch_pkg::op_minus_with_borrow:
      begin
        is_sub = 1'b1;
        carry_in = cur.status[alu_branch_pkg::FLAG_C];
      end
      alu_branch_pkg::op_minus_immediate:
      begin
        is_sub = 1'b1;
        opnd_b = immediate;
      end
      alu_branch_pkg::op_minus_borrow_immediate:
      begin
        is_sub = 1'b1;
        opnd_b = immediate;
        carry_in = cur.status[alu_branch_pkg::FLAG_C];
      end
      alu_branch_pkg::op_and:
      begin
        is_logic = 1'b1;
        logic_out = dest_value & src_value;
      end
      alu_branch_pkg::op_mask_immediate:
      begin
        is_logic = 1'b1;
        logic_out = dest_value & immediate;
      end
      alu_branch_pkg::op_or:
      begin
        is_logic = 1'b1;
        logic_out = dest_value | src_value;
      end
      alu_branch_pkg::op_disjunction_immediate,
      alu_branch_pkg::op_set_bits_masked:
      begin
        is_logic = 1'b1;
        logic_out = dest_value | immediate;
      end
      alu_branch_pkg::op_exclusive_or_reg:
      begin
        is_logic = 1'b1;
        logic_out = dest_value ^ src_value;
      end
      alu_branch_pkg::op_clear_bits_masked:
      begin
        is_logic = 1'b1;
        logic_out = dest_value & (alu_branch_pkg::ALL_ONES - immediate);
      end
      alu_branch_pkg::op_zero_minus_test:
      begin
        is_logic = 1'b1;
        logic_out = dest_value & dest_value;
      end
      alu_branch_pkg::op_zero_register:
      begin
        is_logic = 1'b1;
        logic_out = dest_value ^ dest_value;
      end
      alu_branch_pkg::op_compare_op:
      begin
        is_sub = 1'b1;
        is_cmp = 1'b1;
      end
      alu_branch_pkg::op_compare_with_borrow:
      begin
        is_sub = 1'b1;
        is_cmp = 1'b1;
        carry_in = cur.status[alu_branch_pkg::FLAG_C];
      end
      alu_branch_pkg::op_compare_immediate:
      begin
        is_sub = 1'b1;
        is_cmp = 1'b1;
        opnd_b = immediate;
      end
      default:
        logic_out = dest_value;
    endcase
  end

  // one adder serves add and subtract; borrow is bit 8 of the difference, loaded into C uninverted
  always_comb
  begin
    if (is_sub)
    begin
      sum = {1'b0, dest_value} - {1'b0, opnd_b} - {8'h00, carry_in};
      arith_out = sum[7:0];
      h_flag = (~dest_value[3] & opnd_b[3]) | (opnd_b[3] & arith_out[3])
        | (arith_out[3] & ~dest_value[3]);
      v_flag = (dest_value[7] & ~opnd_b[7] & ~arith_out[7])
        | (~dest_value[7] & opnd_b[7] & arith_out[7]);
    end
    else
    begin
      sum = {1'b0, dest_value} + {1'b0, opnd_b} + {8'h00, carry_in};
      arith_out = sum[7:0];
      h_flag = (dest_value[3] & opnd_b[3]) | (opnd_b[3] & ~arith_out[3])
        | (~arith_out[3] & dest_value[3]);
      v_flag = (dest_value[7] & opnd_b[7] & ~arith_out[7])
        | (~dest_value[7] & ~opnd_b[7] & arith_out[7]);
    end
  end

  // ************************************************************
  // branch and skip conditions
  // ************************************************************
  always_comb
  begin
    cond = 1'b0;
    is_branch = 1'b0;
    is_skip = 1'b0;
    unique case (alu_branch_pkg::op_t'(opcode))
      alu_branch_pkg::op_equal_skip:
      begin
        is_skip = 1'b1;
        cond = dest_value == src_value;
      end
      alu_branch_pkg::op_skip_reg_bit_clear:
      begin
        is_skip = 1'b1;
        cond = ~src_value[bit_select];
      end
      alu_branch_pkg::op_skip_reg_bit_high:
      begin
        is_skip = 1'b1;
        cond = src_value[bit_select];
      end
      alu_branch_pkg::op_skip_port_bit_clear:
      begin
        is_skip = 1'b1;
        cond = ~port_value[bit_select];
      end
      alu_branch_pkg::op_skip_port_bit_high:
      begin
        is_skip = 1'b1;
        cond = port_value[bit_select];
      end
      alu_branch_pkg::op_flag_set_jump:
      begin
        is_branch = 1'b1;
        cond = cur.status[bit_select];
      end
      alu_branch_pkg::op_flag_clear_jump:
      begin
        is_branch = 1'b1;
        cond = ~cur.status[bit_select];
      end
      alu_branch_pkg::op_signed_ge_jump:
      begin
        is_branch = 1'b1;
        cond = ~(cur.status[alu_branch_pkg::FLAG_N]
          ^ cur.status[alu_branch_pkg::FLAG_V]);
      end
      alu_branch_pkg::op_signed_less_jump:
      begin
        is_branch = 1'b1;
        cond = cur.status[alu_branch_pkg::FLAG_N] ^ cur.status[alu_branch_pkg::FLAG_V];
      end
      alu_branch_pkg::op_carry_high_jump,
      alu_branch_pkg::op_unsigned_less_jump:
      begin
        is_branch = 1'b1;
        cond = cur.status[alu_branch_pkg::FLAG_C];
      end
      alu_branch_pkg::op_carry_low_jump,
      alu_branch_pkg::op_unsigned_ge_jump:
      begin
        is_branch = 1'b1;
        cond = ~cur.status[alu_branch_pkg::FLAG_C];
      end
      alu_branch_pkg::op_half_carry_high_jump:
      begin
        is_branch = 1'b1;
        cond = cur.status[alu_branch_pkg::FLAG_H];
      end
      alu_branch_pkg::op_half_carry_low_jump:
      begin
        is_branch = 1'b1;
        cond = ~cur.status[alu_branch_pkg::FLAG_H];
      end
      alu_branch_pkg::op_overflow_high_jump:
      begin
        is_branch = 1'b1;
        cond = cur.status[alu_branch_pkg::FLAG_V];
      end
      alu_branch_pkg::op_overflow_low_jump:
      begin
        is_branch = 1'b1;
        cond = ~cur.status[alu_branch_pkg::FLAG_V];
      end
      alu_branch_pkg::op_irq_enabled_jump:
      begin
        is_branch = 1'b1;
        cond = cur.status[alu_branch_pkg::FLAG_I];
      end
      alu_branch_pkg::op_irq_disabled_jump:
      begin
        is_branch = 1'b1;
        cond = ~cur.status[alu_branch_pkg::FLAG_I];
      end
      alu_branch_pkg::op_transfer_bit_high_jump:
      begin
        is_branch = 1'b1;
        cond = cur.status[alu_branch_pkg::FLAG_T];
      end
      alu_branch_pkg::op_transfer_bit_low_jump:
      begin
        is_branch = 1'b1;
        cond = ~cur.status[alu_branch_pkg::FLAG_T];
      end
      default:
        cond = 1'b0;
    endcase
  end

  // sign extension lets the offset move backwards
  assign rel = {{4{offset[6]}}, offset};

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    next_cur = cur;
    next_cur.result_write = 1'b0;
    next_cur.pc_load = 1'b0;
    if (status_write)
      next_cur.status = status_write_data;
    unique case (cur.state)
      alu_branch_pkg::st_stall:
        next_cur.state = alu_branch_pkg::st_ready;
      alu_branch_pkg::st_stall_two:
        next_cur.state = alu_branch_pkg::st_stall;
      alu_branch_pkg::st_ready:
      begin
        if (issue && (is_add || is_sub))
        begin
          // single cycle update of six flags
          next_cur.status[alu_branch_pkg::FLAG_C] = sum[8];
          next_cur.status[alu_branch_pkg::FLAG_H] = h_flag;
          next_cur.status[alu_branch_pkg::FLAG_V] = v_flag;
          next_cur.status[alu_branch_pkg::FLAG_N] = arith_out[7];
          // subtract forms with borrow in set keep Z only when the result is zero
          next_cur.status[alu_branch_pkg::FLAG_Z] = carry_in && is_sub
            ? (arith_out == 8'h00) & cur.status[alu_branch_pkg::FLAG_Z]
            : (arith_out == 8'h00);
          next_cur.status[alu_branch_pkg::FLAG_S] = arith_out[7] ^ v_flag;
          next_cur.result = arith_out;
          next_cur.result_write = ~is_cmp;
        end
        else if (issue && is_logic)
        begin
          // carry and half-carry are left alone
          next_cur.status[alu_branch_pkg::FLAG_V] = 1'b0;
          next_cur.status[alu_branch_pkg::FLAG_N] = logic_out[7];
          next_cur.status[alu_branch_pkg::FLAG_Z] = logic_out == 8'h00;
          next_cur.status[alu_branch_pkg::FLAG_S] = logic_out[7];
          next_cur.result = logic_out;
          next_cur.result_write = 1'b1;
        end
        else if (issue && alu_branch_pkg::op_t'(opcode) == alu_branch_pkg::op_all_ones_load)
        begin
          next_cur.result = alu_branch_pkg::ALL_ONES;
          next_cur.result_write = 1'b1;
        end
        else if (issue && is_branch)
        begin
          if (cond)
          begin
            next_cur.pc = cur.pc + rel + alu_branch_pkg::PC_STEP_ONE;
            next_cur.pc_load = 1'b1;
            next_cur.state = alu_branch_pkg::st_stall;
          end
          else
            next_cur.pc = cur.pc + alu_branch_pkg::PC_STEP_ONE;
        end
        else if (issue && is_skip)
        begin
          if (cond && next_is_two_word)
          begin
            next_cur.pc = cur.pc + alu_branch_pkg::PC_STEP_THREE;
            next_cur.pc_load = 1'b1;
            next_cur.state = alu_branch_pkg::st_stall_two;
          end
          else if (cond)
          begin
            next_cur.pc = cur.pc + alu_branch_pkg::PC_STEP_TWO;
            next_cur.pc_load = 1'b1;
            next_cur.state = alu_branch_pkg::st_stall;
          end
          else
            next_cur.pc = cur.pc + alu_branch_pkg::PC_STEP_ONE;
        end
        if (issue && !(is_branch || is_skip))
          next_cur.pc = cur.pc + alu_branch_pkg::PC_STEP_ONE;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      cur.state <= alu_branch_pkg::st_ready;
      cur.result <= 8'h00;
      cur.result_write <= 1'b0;
      cur.status <= alu_branch_pkg::STATUS_RESET;
      cur.pc <= alu_branch_pkg::PC_RESET;
      cur.pc_load <= 1'b0;
    end
    else
      cur <= next_cur;
  end

  // issue is ignored while stalled
  assign ready = cur.state == alu_branch_pkg::st_ready;
  assign result = cur.result;
  assign result_write = cur.result_write;
  assign status_flags_reg = cur.status;
  assign pc = cur.pc;
  assign pc_load = cur.pc_load;

endmodule
`default_nettype wire

// [tb/alu_branch_checker.sv]
`default_nettype none
module alu_branch_checker
(
  input wire logic clock,
  input wire logic reset,
  input wire logic issue,
  input wire logic [5:0] opcode,
  input wire logic [7:0] dest_value,
  input wire logic [7:0] src_value,
  input wire logic [6:0] offset,
  input wire logic next_is_two_word,
  input wire logic status_write,
  input wire logic ready,
  input wire logic [7:0] result,
  input wire logic result_write,
  input wire logic [7:0] status_flags_reg,
  input wire logic [10:0] pc,
  input wire logic pc_load
);
  // ****************************************
  // properties at the execute ports
  // ****************************************
  default clocking @(posedge clock);
  endclocking
  default disable iff (reset);
  logic go;
  logic [10:0] k_ext;
  logic c_flag;
  // an external status load in the same cycle would blur whose flags we see
  assign go = issue && ready && !status_write;
  assign k_ext = {{4{offset[6]}}, offset};
  assign c_flag = status_flags_reg[alu_branch_pkg::FLAG_C];
  a_add_sum:
  assert property (go && opcode == alu_branch_pkg::op_add |=> result_write
    && result == $past(dest_value) + $past(src_value)) else $error("sum wrong");
  a_minus_diff:
  assert property (go && opcode == alu_branch_pkg::op_minus |=> result_write
    && result == $past(dest_value) - $past(src_value)) else $error("difference wrong");
  a_and_keeps_ch:
  assert property (go && opcode == alu_branch_pkg::op_and |=> !status_flags_reg[3]
    && status_flags_reg[5] == $past(status_flags_reg[5]) && c_flag == $past(c_flag))
    else $error("and touched carry flags");
  a_ones_no_flags:
  assert property (go && opcode == alu_branch_pkg::op_all_ones_load |=> result == 8'hFF
    && $stable(status_flags_reg)) else $error("ones load wrong");
  a_compare_discards:
  assert property (go && opcode == alu_branch_pkg::op_compare_op |=> !result_write
    && !pc_load) else $error("compare wrote");
  a_carry_taken:
  assert property (go && opcode == alu_branch_pkg::op_carry_high_jump && c_flag
    |=> pc_load && !ready ##1 ready) else $error("taken branch timing");
  a_tbit_target:
  assert property (go && opcode == alu_branch_pkg::op_transfer_bit_high_jump
    && status_flags_reg[6] |=> pc == $past(pc) + 11'h001 + $past(k_ext))
    else $error("branch target wrong");
  a_skip_two_word:
  assert property (go && opcode == alu_branch_pkg::op_equal_skip && next_is_two_word
    && dest_value == src_value |=> pc == $past(pc) + 11'h003 && !ready ##1 !ready ##1 ready)
    else $error("two word skip wrong");
  a_fail_one_cycle:
  assert property (go && opcode == alu_branch_pkg::op_carry_low_jump && c_flag
    |=> !pc_load && ready) else $error("failed branch stalled");
endmodule
bind alu_branch_execute alu_branch_checker i_alu_branch_checker (.clock, .reset, .issue,
  .opcode, .dest_value, .src_value, .offset, .next_is_two_word, .status_write, .ready,
  .result, .result_write, .status_flags_reg, .pc, .pc_load);
`default_nettype wire

// [tb/alu_branch_execute_bench.sv]
`default_nettype none
module alu_branch_execute_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // stimulus and checking
  // ****************************************
  logic clock, reset, issue, next_is_two_word, status_write;
  logic [5:0] opcode;
  logic [7:0] dest_value, src_value, immediate, port_value, status_write_data;
  logic [2:0] bit_select;
  logic [6:0] offset;
  logic ready, result_write, pc_load;
  logic [7:0] result, status_flags_reg;
  logic [10:0] pc, exp_pc;
  int failures, samples_checked;
  // status presets that make each branch take, then fail
  logic [7:0] tk [16] = '{8'h40, 8'h00, 8'h0C, 8'h08, 8'h01, 8'h00, 8'h00, 8'h01,
    8'h20, 8'h00, 8'h08, 8'h00, 8'h80, 8'h00, 8'h40, 8'h00};
  logic [7:0] nt [16] = '{8'h00, 8'h40, 8'h04, 8'h0C, 8'h00, 8'h01, 8'h01, 8'h00,
    8'h00, 8'h20, 8'h00, 8'h08, 8'h00, 8'h80, 8'h00, 8'h40};
  alu_branch_execute i_alu_branch_execute (.clock, .reset, .issue, .opcode, .dest_value,
    .src_value, .immediate, .bit_select, .port_value, .offset, .next_is_two_word,
    .status_write, .status_write_data, .ready, .result, .result_write, .status_flags_reg,
    .pc, .pc_load);
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string what, input logic [10:0] exp, input logic [10:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // status is preloaded one cycle ahead so the issue cycle sees a settled value
  task automatic go(input logic [7:0] pre, input logic [5:0] op, input logic [7:0] d,
    input logic [7:0] s, input logic [7:0] imm, input logic [2:0] bs = 3'h0,
    input logic [7:0] pv = 8'h00, input logic [6:0] k = 7'h00, input logic tw = 1'b0);
    @(posedge clock);
    status_write <= 1'b1;
    status_write_data <= pre;
    @(posedge clock);
    status_write <= 1'b0;
    issue <= 1'b1;
    opcode <= op;
    dest_value <= d;
    src_value <= s;
    immediate <= imm;
    bit_select <= bs;
    port_value <= pv;
    offset <= k;
    next_is_two_word <= tw;
    @(posedge clock);
    issue <= 1'b0;
    #1;
  endtask
  task automatic expect_out(input logic [7:0] res, input logic wr, input logic [7:0] st,
    input logic [10:0] npc, input logic ld, input int stall);
    if (wr)
      check("result", 11'(res), 11'(result));
    check("result_write", 11'(wr), 11'(result_write));
    check("status", 11'(st), 11'(status_flags_reg));
    check("pc", npc, pc);
    check("pc_load", 11'(ld), 11'(pc_load));
    repeat (stall)
    begin
      check("ready in stall", 11'h000, 11'(ready));
      @(posedge clock);
      #1;
    end
    check("ready", 11'h001, 11'(ready));
    exp_pc = npc;
  endtask
  task automatic alu(input logic [7:0] pre, input logic [5:0] op, input logic [7:0] d,
    input logic [7:0] s, input logic [7:0] imm, input logic [7:0] res, input logic wr,
    input logic [7:0] st);
    go(pre, op, d, s, imm);
    expect_out(res, wr, st, exp_pc + 11'h001, 1'b0, 0);
  endtask
  task automatic t_arith;
    alu(8'h00, alu_branch_pkg::op_add, 8'h0F, 8'h01, 8'h00, 8'h10, 1'b1, 8'h20);
    alu(8'hC1, alu_branch_pkg::op_add_carry, 8'hFF, 8'h00, 8'h00, 8'h00, 1'b1, 8'hE3);
    alu(8'h00, alu_branch_pkg::op_minus, 8'h80, 8'h01, 8'h00, 8'h7F, 1'b1, 8'h38);
    alu(8'h03, alu_branch_pkg::op_minus_with_borrow, 8'h05, 8'h04, 8'h00, 8'h00, 1'b1,
      8'h02);
    alu(8'h00, alu_branch_pkg::op_minus_immediate, 8'h10, 8'h00, 8'h20, 8'hF0, 1'b1,
      8'h15);
    alu(8'h01, alu_branch_pkg::op_minus_borrow_immediate, 8'h20, 8'h00, 8'h1F, 8'h00, 1'b1,
      8'h20);
  endtask
  task automatic t_logic;
    alu(8'h3F, alu_branch_pkg::op_and, 8'hF0, 8'h3C, 8'h00, 8'h30, 1'b1, 8'h21);
    alu(8'h3F, alu_branch_pkg::op_mask_immediate, 8'h80, 8'h00, 8'h81, 8'h80, 1'b1,
      8'h35);
    alu(8'h3F, alu_branch_pkg::op_or, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1, 8'h23);
    alu(8'h3F, alu_branch_pkg::op_disjunction_immediate, 8'h01, 8'h00, 8'h80, 8'h81, 1'b1,
      8'h35);
    alu(8'h3F, alu_branch_pkg::op_exclusive_or_reg, 8'hAA, 8'h55, 8'h00, 8'hFF, 1'b1,
      8'h35);
    alu(8'h3F, alu_branch_pkg::op_set_bits_masked, 8'h01, 8'h00, 8'h02, 8'h03, 1'b1,
      8'h21);
    alu(8'h3F, alu_branch_pkg::op_clear_bits_masked, 8'hFF, 8'h00, 8'h0F, 8'hF0, 1'b1,
      8'h35);
    alu(8'h3F, alu_branch_pkg::op_zero_minus_test, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1,
      8'h23);
    alu(8'h3F, alu_branch_pkg::op_zero_register, 8'h5A, 8'h5A, 8'h00, 8'h00, 1'b1,
      8'h23);
    alu(8'h3F, alu_branch_pkg::op_all_ones_load, 8'h12, 8'h00, 8'h00, 8'hFF, 1'b1,
      8'h3F);
  endtask
  task automatic t_compare;
    alu(8'h00, alu_branch_pkg::op_compare_op, 8'h10, 8'h10, 8'h00, 8'h00, 1'b0, 8'h02);
    alu(8'h03, alu_branch_pkg::op_compare_with_borrow, 8'h10, 8'h0F, 8'h00, 8'h00, 1'b0,
      8'h22);
    alu(8'h00, alu_branch_pkg::op_compare_immediate, 8'h00, 8'h00, 8'h01, 8'h00, 1'b0,
      8'h35);
  endtask
  task automatic t_branch;
    logic [6:0] k;
    logic [5:0] op;
    logic [10:0] npc;
    for (int i = 0; i < 16; i++)
    begin
      k = i[0] ? 7'h05 : 7'h7E;
      op = 6'(alu_branch_pkg::op_flag_set_jump) + 6'(i);
      go(tk[i], op, 8'h00, 8'h00, 8'h00, 3'h6, 8'h00, k);
      npc = exp_pc + 11'h001 + {{4{k[6]}}, k};
      expect_out(8'h00, 1'b0, tk[i], npc, 1'b1, 1);
      go(nt[i], op, 8'h00, 8'h00, 8'h00, 3'h6, 8'h00, k);
      expect_out(8'h00, 1'b0, nt[i], exp_pc + 11'h001, 1'b0, 0);
    end
  endtask
  task automatic skip(input logic [5:0] op, input logic [7:0] d, input logic [7:0] s,
    input logic [2:0] bs, input logic tw, input logic hit);
    logic [10:0] step;
    step = hit ? (tw ? 11'h003 : 11'h002) : 11'h001;
    go(8'h00, op, d, s, 8'h00, bs, d, 7'h00, tw);
    expect_out(8'h00, 1'b0, 8'h00, exp_pc + step, hit, hit ? 1 + int'(tw) : 0);
  endtask
  task automatic t_skip;
    skip(alu_branch_pkg::op_equal_skip, 8'h33, 8'h33, 3'h0, 1'b0, 1'b1);
    skip(alu_branch_pkg::op_equal_skip, 8'h33, 8'h33, 3'h0, 1'b1, 1'b1);
    skip(alu_branch_pkg::op_equal_skip, 8'h33, 8'h32, 3'h0, 1'b1, 1'b0);
    skip(alu_branch_pkg::op_skip_reg_bit_clear, 8'h7F, 8'h7F, 3'h7, 1'b0, 1'b1);
    skip(alu_branch_pkg::op_skip_reg_bit_high, 8'h7F, 8'h7F, 3'h7, 1'b0, 1'b0);
    skip(alu_branch_pkg::op_skip_port_bit_clear, 8'hF7, 8'h00, 3'h3, 1'b0, 1'b1);
    skip(alu_branch_pkg::op_skip_port_bit_high, 8'h08, 8'h00, 3'h3, 1'b1, 1'b1);
    skip(alu_branch_pkg::op_skip_port_bit_high, 8'hF7, 8'h00, 3'h3, 1'b1, 1'b0);
  endtask
  initial
  begin
    {reset, issue, next_is_two_word, status_write} = 4'h8;
    {opcode, dest_value, src_value, immediate, port_value} = 38'h0;
    {status_write_data, bit_select, offset} = 18'h0;
    {failures, samples_checked} = 64'h0;
    exp_pc = 11'h000;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    t_arith();
    t_logic();
    t_compare();
    t_branch();
    t_skip();
    print_verdict();
  end
endmodule
`default_nettype wire
